/* File: logic/atc_timer.sv */
// Timer clock domain logic: holding registers, prescaler, count, compare outputs, flags
`timescale 1ns/1ps
// Functional notes
// - Writes land in a holding register, moved after two oscillator rising edges in async mode, next cycle otherwise.
// - Count, both compares and both controls each own one holding register.
// - Status register shows one update-busy flag per holding register.
// - Compare match is suppressed while count or compare write is pending.
// - Wake-up starts on the timer clock cycle after the interrupt condition.
// - Count reads use a copy refreshed on oscillator edges in async mode, frozen in sleep; every cycle in sync mode.
// - Flags reach the processor three cycles after the timer event.
// - Compare output pins change on the timer clock, unsynchronised.
// - Source is processor clock by default; async select uses oscillator pin.
// - Prescaler offers stop, undivided, 8, 32, 64, 128, 256 and 1024.
// - Prescaler reset bit in general control clears the prescaler.
// - Oscillator runs in async mode except in power-down.
// - Output mode selects detached, toggle, clear or set on match.
// - The two reserved bits of the waveform control register read zero.
module atc_timer (
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic osc_in_pin,
    input wire logic sleep_power_save,
    input wire logic sleep_power_down,
    output logic osc_pins_detached,
    output logic osc_enable,
    output logic out_a_pin,
    output logic out_a_oe,
    output logic out_b_pin,
    output logic out_b_oe,
    output logic wake_request,
    output logic [2:0] irq_flags
);
    typedef struct packed {
        logic osc_s1;
        logic osc_s2;
        logic osc_s3;
        logic osc_lvl;
        logic async_sel;
        logic osc_en;
        logic [7:0] wave;
        logic [2:0] clk_sel;
        logic [7:0] count;
        logic [7:0] count_copy;
        logic [7:0] cmp_a;
        logic [7:0] cmp_b;
        logic [9:0] psc;
        logic [2:0] pipe0;
        logic [2:0] pipe1;
        logic [2:0] flags;
        logic out_a;
        logic out_b;
        logic oe_a;
        logic oe_b;
        logic wake_pending;
        logic wake;
        logic [7:0] rdata;
    } atc_state_t;

    atc_state_t st_reg;
    atc_state_t st_next;

    logic osc_edge;
    logic source_tick;
    logic [9:0] tap_mask;
    logic tick;
    logic match_a;
    logic match_b;
    logic [2:0] evt;
    logic psc_reset_write;
    logic [2:0] flag_clear;
    logic [4:0] write_req;
    logic [7:0] hold_data [5];
    logic [4:0] busy;
    logic [4:0] load;
    logic [7:0] slot_addr [5];
    atc_pkg::atc_out_mode_t mode_a;
    atc_pkg::atc_out_mode_t mode_b;

    // Filtered oscillator edge: second and third stages must agree
    assign osc_edge = (st_reg.osc_s2 == st_reg.osc_s3) && st_reg.osc_s3 && !st_reg.osc_lvl;
    // Source clock is the processor clock unless async is selected
    assign source_tick = st_reg.async_sel ? osc_edge : 1'b1;

    // Prescaler tap selection
    always_comb begin
        tap_mask = atc_pkg::MASK_DIV8;
        tick = 1'b0;
        case (atc_pkg::atc_clk_sel_t'(st_reg.clk_sel))
            atc_pkg::SEL_STOP: tap_mask = atc_pkg::MASK_DIV8;
            atc_pkg::SEL_DIV1: tap_mask = '0;
            atc_pkg::SEL_DIV8: tap_mask = atc_pkg::MASK_DIV8;
            atc_pkg::SEL_DIV32: tap_mask = atc_pkg::MASK_DIV32;
            atc_pkg::SEL_DIV64: tap_mask = atc_pkg::MASK_DIV64;
            atc_pkg::SEL_DIV128: tap_mask = atc_pkg::MASK_DIV128;
            atc_pkg::SEL_DIV256: tap_mask = atc_pkg::MASK_DIV256;
            atc_pkg::SEL_DIV1024: tap_mask = atc_pkg::MASK_DIV1024;
            default: tap_mask = atc_pkg::MASK_DIV8;
        endcase
        if (st_reg.clk_sel != atc_pkg::SEL_STOP) begin
            tick = source_tick && ((st_reg.psc & tap_mask) == tap_mask);
        end
    end

    // Compare match is blocked while count or compare transfer is pending
    assign match_a = tick && (st_reg.count == st_reg.cmp_a)
        && !busy[atc_pkg::HOLD_COUNT] && !busy[atc_pkg::HOLD_CMP_A];
    assign match_b = tick && (st_reg.count == st_reg.cmp_b)
        && !busy[atc_pkg::HOLD_COUNT] && !busy[atc_pkg::HOLD_CMP_B];
    assign evt[atc_pkg::FLAG_OVF] = tick && !load[atc_pkg::HOLD_COUNT] && (st_reg.count == atc_pkg::COUNT_MAX);
    assign evt[atc_pkg::FLAG_CMP_A] = match_a;
    assign evt[atc_pkg::FLAG_CMP_B] = match_b;

    assign mode_a = atc_pkg::atc_out_mode_t'(st_reg.wave[atc_pkg::OUT_A_MODE_LSB +: 2]);
    assign mode_b = atc_pkg::atc_out_mode_t'(st_reg.wave[atc_pkg::OUT_B_MODE_LSB +: 2]);

    // Write decode for side effects
    assign psc_reset_write = reg_write && (reg_addr == atc_pkg::ADDR_GENERAL)
        && reg_wdata[atc_pkg::GENERAL_PSC_RESET_BIT];
    assign flag_clear = (reg_write && (reg_addr == atc_pkg::ADDR_FLAGS)) ? reg_wdata[2:0] : 3'h0;

    // Slot addresses of the five holding registers
    assign slot_addr[atc_pkg::HOLD_COUNT] = atc_pkg::ADDR_COUNT;
    assign slot_addr[atc_pkg::HOLD_CMP_A] = atc_pkg::ADDR_CMP_A;
    assign slot_addr[atc_pkg::HOLD_CMP_B] = atc_pkg::ADDR_CMP_B;
    assign slot_addr[atc_pkg::HOLD_WAVE] = atc_pkg::ADDR_WAVE;
    assign slot_addr[atc_pkg::HOLD_CTRL_B] = atc_pkg::ADDR_CTRL_B;

    // One independent holding register per asynchronously updated register
    for (genvar i = 0; i < atc_pkg::HOLD_NUM; i++) begin : g_hold
        assign write_req[i] = reg_write && (reg_addr == slot_addr[i]);
        atc_hold u_hold (
            .clock(clock),
            .reset(reset),
            .write_req(write_req[i]),
            .write_data(reg_wdata),
            .osc_edge(osc_edge),
            .async_mode(st_reg.async_sel),
            .hold_data(hold_data[i]),
            .busy(busy[i]),
            .load(load[i])
        );
    end

    // Next-state logic
    always_comb begin
        st_next = st_reg;
        // Oscillator pin synchroniser
        st_next.osc_s1 = osc_in_pin;
        st_next.osc_s2 = st_reg.osc_s1;
        st_next.osc_s3 = st_reg.osc_s2;
        if (st_reg.osc_s2 == st_reg.osc_s3) begin
            st_next.osc_lvl = st_reg.osc_s3;
        end
        // Prescaler, cleared by software for a known phase
        if (psc_reset_write) begin
            st_next.psc = '0;
        end else if (source_tick) begin
            st_next.psc = st_reg.psc + atc_pkg::PSC_STEP;
        end
        // Transfers from holding registers into destinations
        if (load[atc_pkg::HOLD_WAVE]) begin
            st_next.wave = hold_data[atc_pkg::HOLD_WAVE] & atc_pkg::WAVE_RW_MASK;
        end
        if (load[atc_pkg::HOLD_CTRL_B]) begin
            st_next.clk_sel = hold_data[atc_pkg::HOLD_CTRL_B][2:0];
        end
        if (load[atc_pkg::HOLD_CMP_A]) begin
            st_next.cmp_a = hold_data[atc_pkg::HOLD_CMP_A];
        end
        if (load[atc_pkg::HOLD_CMP_B]) begin
            st_next.cmp_b = hold_data[atc_pkg::HOLD_CMP_B];
        end
        // Counter: a transferred write wins over counting
        if (load[atc_pkg::HOLD_COUNT]) begin
            st_next.count = hold_data[atc_pkg::HOLD_COUNT];
        end else if (tick) begin
            st_next.count = st_reg.count + atc_pkg::COUNT_STEP;
        end
        // Compare outputs switch directly on the timer tick
        if (match_a) begin
            case (mode_a)
                atc_pkg::OUT_DETACHED: st_next.out_a = st_reg.out_a;
                atc_pkg::OUT_TOGGLE: st_next.out_a = !st_reg.out_a;
                atc_pkg::OUT_CLEAR: st_next.out_a = 1'b0;
                atc_pkg::OUT_SET: st_next.out_a = 1'b1;
                default: st_next.out_a = st_reg.out_a;
            endcase
        end
        if (match_b) begin
            case (mode_b)
                atc_pkg::OUT_DETACHED: st_next.out_b = st_reg.out_b;
                atc_pkg::OUT_TOGGLE: st_next.out_b = !st_reg.out_b;
                atc_pkg::OUT_CLEAR: st_next.out_b = 1'b0;
                atc_pkg::OUT_SET: st_next.out_b = 1'b1;
                default: st_next.out_b = st_reg.out_b;
            endcase
        end
        st_next.oe_a = (mode_a != atc_pkg::OUT_DETACHED);
        st_next.oe_b = (mode_b != atc_pkg::OUT_DETACHED);
        // Flag synchroniser; a new event wins over a clear
        st_next.pipe0 = evt;
        st_next.pipe1 = st_reg.pipe0;
        st_next.flags = (st_reg.flags & ~flag_clear) | st_reg.pipe1;
        // Readable count copy, refreshed every cycle in sync mode, on oscillator edges outside power-save in async mode
        if (!st_reg.async_sel) begin
            st_next.count_copy = st_reg.count;
        end else if (osc_edge && !sleep_power_save) begin
            st_next.count_copy = st_reg.count;
        end
        // Wake-up starts on the timer cycle after the condition
        if (!sleep_power_save) begin
            st_next.wake_pending = 1'b0;
            st_next.wake = 1'b0;
        end else begin
            if (|evt) begin
                st_next.wake_pending = 1'b1;
            end
            if (st_reg.wake_pending && source_tick) begin
                st_next.wake = 1'b1;
            end
        end
        // Oscillator runs in async mode unless powered down
        st_next.osc_en = st_reg.async_sel && !sleep_power_down;
        if (reg_write && (reg_addr == atc_pkg::ADDR_STATUS)) begin
            st_next.async_sel = reg_wdata[atc_pkg::STATUS_ASYNC_BIT];
        end
        // Read data, valid only in the cycle after the read strobe
        st_next.rdata = atc_pkg::BYTE_ZERO;
        if (reg_read) begin
            case (reg_addr)
                atc_pkg::ADDR_WAVE: st_next.rdata = st_reg.wave & atc_pkg::WAVE_RW_MASK;
                atc_pkg::ADDR_CTRL_B: st_next.rdata = {5'h00, st_reg.clk_sel};
                atc_pkg::ADDR_COUNT: st_next.rdata = st_reg.count_copy;
                atc_pkg::ADDR_CMP_A: st_next.rdata = st_reg.cmp_a;
                atc_pkg::ADDR_CMP_B: st_next.rdata = st_reg.cmp_b;
                atc_pkg::ADDR_STATUS: st_next.rdata = {2'h0, st_reg.async_sel, busy};
                atc_pkg::ADDR_FLAGS: st_next.rdata = {5'h00, st_reg.flags};
                default: st_next.rdata = atc_pkg::BYTE_ZERO;
            endcase
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flops
    assign reg_rdata = st_reg.rdata;
    assign osc_pins_detached = st_reg.async_sel;
    assign osc_enable = st_reg.osc_en;
    assign out_a_pin = st_reg.out_a;
    assign out_a_oe = st_reg.oe_a;
    assign out_b_pin = st_reg.out_b;
    assign out_b_oe = st_reg.oe_b;
    assign wake_request = st_reg.wake;
    assign irq_flags = st_reg.flags;

    property p_busy_set;
        @(posedge clock) disable iff (reset)
        (reg_write && reg_addr == atc_pkg::ADDR_CMP_A) |=> busy[1];
    endproperty
    a_busy_set: assert property (p_busy_set) else $error("busy flag not set by write");

    property p_separate_slots;
        @(posedge clock) disable iff (reset)
        (reg_write && reg_addr == atc_pkg::ADDR_CMP_A && st_reg.async_sel && busy[2] && !load[2] && !osc_edge)
            |=> (busy[2] && $stable(hold_data[2]));
    endproperty
    a_separate_slots: assert property (p_separate_slots) else $error("write disturbed other slot");

    property p_match_gate;
        @(posedge clock) disable iff (reset)
        (busy[atc_pkg::HOLD_COUNT] || busy[atc_pkg::HOLD_CMP_A]) |=> !st_reg.pipe0[atc_pkg::FLAG_CMP_A];
    endproperty
    a_match_gate: assert property (p_match_gate) else $error("match while write pending");

    property p_flag_sync;
        @(posedge clock) disable iff (reset)
        evt[0] |-> ##3 irq_flags[0];
    endproperty
    a_flag_sync: assert property (p_flag_sync) else $error("overflow flag not set after three cycles");

    property p_reserved_zero;
        @(posedge clock) disable iff (reset)
        (reg_read && reg_addr == atc_pkg::ADDR_WAVE) |=> (reg_rdata[3:2] == 2'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

    property p_psc_reset;
        @(posedge clock) disable iff (reset)
        psc_reset_write |=> (st_reg.psc == 10'h000);
    endproperty
    a_psc_reset: assert property (p_psc_reset) else $error("prescaler not cleared");

    property p_out_on_tick;
        @(posedge clock) disable iff (reset)
        !$stable(out_a_pin) |-> $past(tick);
    endproperty
    a_out_on_tick: assert property (p_out_on_tick) else $error("output changed off timer tick");

    property p_out_clear;
        @(posedge clock) disable iff (reset)
        (match_a && mode_a == atc_pkg::OUT_CLEAR) |=> !out_a_pin;
    endproperty
    a_out_clear: assert property (p_out_clear) else $error("clear on match failed");

    property p_copy_hold;
        @(posedge clock) disable iff (reset)
        (st_reg.async_sel && (!osc_edge || sleep_power_save)) |=> $stable(st_reg.count_copy);
    endproperty
    a_copy_hold: assert property (p_copy_hold) else $error("count copy changed without edge");

    property p_wake_tick;
        @(posedge clock) disable iff (reset)
        $rose(wake_request) |-> ($past(source_tick) && $past(st_reg.wake_pending));
    endproperty
    a_wake_tick: assert property (p_wake_tick) else $error("wake-up not on timer cycle");

    property p_osc_run;
        @(posedge clock) disable iff (reset)
        (st_reg.async_sel && !sleep_power_down) |=> osc_enable;
    endproperty
    a_osc_run: assert property (p_osc_run) else $error("oscillator stopped in async mode");
endmodule

/* File: logic/atc_pkg.sv */
// Constants, register map and mode encodings for the asynchronous timer clock block
package atc_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_WAVE = 8'hb0;
    localparam logic [7:0] ADDR_CTRL_B = 8'hb1;
    localparam logic [7:0] ADDR_COUNT = 8'hb2;
    localparam logic [7:0] ADDR_CMP_A = 8'hb3;
    localparam logic [7:0] ADDR_CMP_B = 8'hb4;
    localparam logic [7:0] ADDR_GENERAL = 8'hb5;
    localparam logic [7:0] ADDR_STATUS = 8'hb6;
    localparam logic [7:0] ADDR_FLAGS = 8'hb7;

    // Field layouts and reset values
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] WAVE_RW_MASK = 8'hf3;
    localparam logic [7:0] CTRL_B_RW_MASK = 8'h07;
    localparam int OUT_A_MODE_LSB = 6;
    localparam int OUT_B_MODE_LSB = 4;
    localparam int STATUS_ASYNC_BIT = 5;
    localparam int GENERAL_PSC_RESET_BIT = 1;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_STEP = 8'h01;

    // Holding register slots; busy flag of slot i sits at status bit i
    localparam int HOLD_COUNT = 0;
    localparam int HOLD_CMP_A = 1;
    localparam int HOLD_CMP_B = 2;
    localparam int HOLD_WAVE = 3;
    localparam int HOLD_CTRL_B = 4;
    localparam int HOLD_NUM = 5;
    localparam logic [1:0] HOLD_LAST_EDGE = 2'h1;
    localparam logic [1:0] HOLD_STEP = 2'h1;

    // Flag positions
    localparam int FLAG_OVF = 0;
    localparam int FLAG_CMP_A = 1;
    localparam int FLAG_CMP_B = 2;
    localparam int FLAG_NUM = 3;

    // Prescaler
    localparam int PSC_W = 10;
    localparam logic [9:0] PSC_STEP = 10'h001;
    localparam logic [9:0] MASK_DIV8 = 10'h007;
    localparam logic [9:0] MASK_DIV32 = 10'h01f;
    localparam logic [9:0] MASK_DIV64 = 10'h03f;
    localparam logic [9:0] MASK_DIV128 = 10'h07f;
    localparam logic [9:0] MASK_DIV256 = 10'h0ff;
    localparam logic [9:0] MASK_DIV1024 = 10'h3ff;

    typedef enum logic [2:0] {
        SEL_STOP = 3'h0,
        SEL_DIV1 = 3'h1,
        SEL_DIV8 = 3'h2,
        SEL_DIV32 = 3'h3,
        SEL_DIV64 = 3'h4,
        SEL_DIV128 = 3'h5,
        SEL_DIV256 = 3'h6,
        SEL_DIV1024 = 3'h7
    } atc_clk_sel_t;

    typedef enum logic [1:0] {
        OUT_DETACHED = 2'h0,
        OUT_TOGGLE = 2'h1,
        OUT_CLEAR = 2'h2,
        OUT_SET = 2'h3
    } atc_out_mode_t;
endpackage

/* File: logic/atc_hold.sv */
// One holding register with its update-busy flag and two-edge transfer in async mode
`timescale 1ns/1ps
module atc_hold (
    input wire logic clock,
    input wire logic reset,
    input wire logic write_req,
    input wire logic [7:0] write_data,
    input wire logic osc_edge,
    input wire logic async_mode,
    output logic [7:0] hold_data,
    output logic busy,
    output logic load
);
    typedef struct packed {
        logic [7:0] hold;
        logic busy;
        logic [1:0] stage;
        logic load;
    } atc_hold_state_t;

    atc_hold_state_t st_reg;
    atc_hold_state_t st_next;

    // Capture on write, transfer next cycle in sync mode or after the second oscillator edge in async mode
    always_comb begin
        st_next = st_reg;
        st_next.load = 1'b0;
        if (write_req) begin
            st_next.hold = write_data;
            st_next.busy = 1'b1;
            st_next.stage = 2'h0;
        end else if (st_reg.busy) begin
            if (!async_mode) begin
                st_next.busy = 1'b0;
                st_next.load = 1'b1;
            end else if (osc_edge) begin
                if (st_reg.stage == atc_pkg::HOLD_LAST_EDGE) begin
                    st_next.busy = 1'b0;
                    st_next.load = 1'b1;
                    st_next.stage = 2'h0;
                end else begin
                    st_next.stage = st_reg.stage + atc_pkg::HOLD_STEP;
                end
            end
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hold_data = st_reg.hold;
    assign busy = st_reg.busy;
    assign load = st_reg.load;

    property p_two_edges;
        @(posedge clock) disable iff (reset)
        (st_reg.load && $past(async_mode)) |-> ($past(osc_edge) && $past(st_reg.stage) == 2'h1);
    endproperty
    a_two_edges: assert property (p_two_edges) else $error("transfer without two oscillator edges");
endmodule

/* File: bench/atc_osc_model.sv */
// Crystal oscillator model driving the timer oscillator input pin
`timescale 1ns/1ps
module atc_osc_model #(
    parameter real HALF_NS = 50.0
) (
    input wire logic osc_enable,
    output logic osc_in_pin
);
    // Oscillates only while enabled and rests low otherwise, so no edge appears out of nowhere
    initial begin
        osc_in_pin = 1'b0;
        forever begin
            if (osc_enable === 1'b1) begin
                #(HALF_NS) osc_in_pin = ~osc_in_pin;
            end else begin
                osc_in_pin = 1'b0;
                @(osc_enable);
            end
        end
    end
endmodule

/* File: bench/tb_async_timer_clock_domain.sv */
// Self-checking bench for the asynchronous timer clock block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_total++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_async_timer_clock_domain;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} atc_row_t;
    logic clock, reset, reg_write, reg_read, sleep_power_save, sleep_power_down;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v, w;
    logic osc_in_pin, osc_pins_detached, osc_enable, out_a_pin, out_a_oe, out_b_pin, out_b_oe, wake_request, p;
    logic [2:0] irq_flags;
    int err_total = 0;
    int checks = 0;
    int n;
    int divs[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    atc_row_t rows[9] = '{
        '{atc_pkg::ADDR_WAVE, 8'hff, 8'hf3}, '{atc_pkg::ADDR_CTRL_B, 8'hff, 8'h07},
        '{atc_pkg::ADDR_CTRL_B, 8'h00, 8'h00}, '{atc_pkg::ADDR_CMP_A, 8'h5a, 8'h5a},
        '{atc_pkg::ADDR_CMP_B, 8'ha5, 8'ha5}, '{atc_pkg::ADDR_COUNT, 8'h3c, 8'h3c},
        '{atc_pkg::ADDR_GENERAL, 8'hff, 8'h00}, '{8'hc0, 8'hff, 8'h00}, '{atc_pkg::ADDR_WAVE, 8'h00, 8'h00}};

    atc_timer dut (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .osc_in_pin(osc_in_pin),
        .sleep_power_save(sleep_power_save), .sleep_power_down(sleep_power_down),
        .osc_pins_detached(osc_pins_detached), .osc_enable(osc_enable), .out_a_pin(out_a_pin),
        .out_a_oe(out_a_oe), .out_b_pin(out_b_pin), .out_b_oe(out_b_oe), .wake_request(wake_request),
        .irq_flags(irq_flags));
    atc_osc_model osc (.osc_enable(osc_enable), .osc_in_pin(osc_in_pin));

    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Idle cycles with both strobes low
    task automatic cyc(input int k);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        repeat (k) @(posedge clock);
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        reg_read <= 1'b0;
        @(posedge clock);
    endtask

    // One-cycle read strobe, data taken in the following cycle only
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_read <= 1'b1;
        reg_write <= 1'b0;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clock);
    endtask

    // Poll the status register until no transfer is pending, bounded
    task automatic wait_idle(output int k);
        k = 0;
        do begin
            rd(atc_pkg::ADDR_STATUS, v);
            k += 2;
        end while (v[4:0] !== 5'h00 && k < 400);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog cuts a hang short
    initial begin
        repeat (60000) @(posedge clock);
        err_total++;
        $display("watchdog expired");
        stop_test();
    end

    initial begin
        {reset, reg_write, reg_read, sleep_power_save, sleep_power_down} = 5'h10;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        cyc(10);
        reset <= 1'b0;
        cyc(1);
        // Reset state
        `CHK("detached", 1'b0, osc_pins_detached)
        rd(atc_pkg::ADDR_STATUS, v);
        `CHK("status", 8'h00, v)
        rd(atc_pkg::ADDR_WAVE, v);
        `CHK("wave reset", 8'h00, v)
        $display("test reset done");
        // Register rows in synchronous mode
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            cyc(3);
            rd(rows[i].a, v);
            `CHK("row", rows[i].e, v)
        end
        $display("test registers done");
        // Every prescaler tap, phase fixed by prescaler reset
        for (int s = 0; s < 8; s++) begin
            wr(atc_pkg::ADDR_CTRL_B, 8'h00);
            wr(atc_pkg::ADDR_COUNT, 8'h00);
            wr(atc_pkg::ADDR_GENERAL, 8'h02);
            wr(atc_pkg::ADDR_CTRL_B, 8'(s));
            cyc(s == 0 ? 64 : 16 * divs[s]);
            rd(atc_pkg::ADDR_COUNT, v);
            `CHK("tap", 1'b1, (s == 0) ? (v == 8'h00) : (v >= 8'h0d && v <= 8'h11))
        end
        $display("test prescaler done");
        // Compare output modes: set, clear, toggle, detached
        wr(atc_pkg::ADDR_CTRL_B, 8'h00);
        wr(atc_pkg::ADDR_CMP_A, 8'h40);
        wr(atc_pkg::ADDR_CMP_B, 8'h40);
        wr(atc_pkg::ADDR_CTRL_B, 8'h01);
        for (int m = 3; m >= 2; m--) begin
            wr(atc_pkg::ADDR_WAVE, {2'(m), 2'(m), 4'h0});
            cyc(300);
            @(negedge clock);
            `CHK("out a", m == 3, out_a_pin)
            `CHK("out b", m == 3, out_b_pin)
            `CHK("out b oe", 1'b1, out_b_oe)
            cyc(1);
        end
        wr(atc_pkg::ADDR_WAVE, 8'h50);
        cyc(300);
        @(negedge clock);
        p = out_a_pin;
        cyc(256);
        @(negedge clock);
        `CHK("toggle", ~p, out_a_pin)
        cyc(1);
        wr(atc_pkg::ADDR_WAVE, 8'h00);
        cyc(4);
        `CHK("detached oe", 1'b0, out_a_oe)
        wr(atc_pkg::ADDR_CTRL_B, 8'h00);
        $display("test outputs done");
        // Asynchronous mode: holding registers and busy flags
        wr(atc_pkg::ADDR_STATUS, 8'h20);
        cyc(3);
        `CHK("pins", 1'b1, osc_pins_detached)
        `CHK("osc on", 1'b1, osc_enable)
        wr(atc_pkg::ADDR_CMP_A, 8'h77);
        wr(atc_pkg::ADDR_WAVE, 8'h03);
        rd(atc_pkg::ADDR_STATUS, v);
        `CHK("busy", 8'h2a, v)
        wait_idle(n);
        `CHK("two edges", 1'b1, n >= 16 && n <= 50)
        rd(atc_pkg::ADDR_CMP_A, v);
        `CHK("cmp a", 8'h77, v)
        wr(atc_pkg::ADDR_COUNT, 8'h10);
        wr(atc_pkg::ADDR_CMP_B, 8'h99);
        wr(atc_pkg::ADDR_CMP_A, 8'h77);
        wait_idle(n);
        rd(atc_pkg::ADDR_CMP_B, v);
        `CHK("cmp b", 8'h99, v)
        $display("test holding done");
        // Overflow flag crossing and write-one clear
        wr(atc_pkg::ADDR_FLAGS, 8'h07);
        wr(atc_pkg::ADDR_COUNT, 8'hfd);
        wr(atc_pkg::ADDR_CTRL_B, 8'h01);
        wait_idle(n);
        cyc(200);
        `CHK("ovf", 1'b1, irq_flags[0])
        wr(atc_pkg::ADDR_FLAGS, 8'h01);
        rd(atc_pkg::ADDR_FLAGS, v);
        `CHK("ovf clear", 1'b0, v[0])
        $display("test flags done");
        // Wake from power-save and frozen count copy
        wr(atc_pkg::ADDR_COUNT, 8'hfd);
        wait_idle(n);
        sleep_power_save <= 1'b1;
        n = 0;
        while (wake_request !== 1'b1 && n < 400) begin
            cyc(1);
            n++;
        end
        `CHK("wake", 1'b1, wake_request)
        rd(atc_pkg::ADDR_COUNT, v);
        cyc(60);
        rd(atc_pkg::ADDR_COUNT, w);
        `CHK("frozen copy", v, w)
        sleep_power_save <= 1'b0;
        wr(atc_pkg::ADDR_CMP_A, 8'h77);
        wait_idle(n);
        rd(atc_pkg::ADDR_COUNT, w);
        `CHK("count after wake", 1'b1, w >= 8'h01 && w <= 8'h0c)
        // Power-down stops the oscillator
        sleep_power_down <= 1'b1;
        cyc(3);
        `CHK("osc off", 1'b0, osc_enable)
        sleep_power_down <= 1'b0;
        cyc(3);
        $display("test sleep done");
        // Reset in mid-run returns the block to its idle state
        reset <= 1'b1;
        cyc(3);
        reset <= 1'b0;
        cyc(1);
        `CHK("osc reset", 1'b0, osc_enable)
        rd(atc_pkg::ADDR_STATUS, v);
        `CHK("status reset", 8'h00, v)
        $display("test mid reset done");
        stop_test();
    end
endmodule
